// >>> verilog/deser_defs.svh
// timing and layout constants for the seven to one lane deserializer
`ifndef DESER_DEFS_SVH
`define DESER_DEFS_SVH

`define LANE_BITS          7
`define LANE_COUNT         3
`define WORD_BITS          21
`define CLK_PERIOD_NS      40
`define LOCK_TIME_NS       1000000
`define LOCK_CYCLES        ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_TIME_NS        400
`define OFF_CYCLES         (`OFF_TIME_NS / `CLK_PERIOD_NS)
`define LINK_MIN_PERIOD_NS 14.7
`define LINK_MAX_PERIOD_NS 32.4
`define LOCK_EDGES         8

`endif

// >>> verilog/deser_pkg.sv
// types shared by the deserializer files
`default_nettype none
package deser_pkg;
  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] neg;
  } lane_pins_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ACQUIRE,
    ST_LOCKED
  } lock_state_t;
endpackage
`default_nettype wire

// >>> verilog/lane_shifter.sv
// one serial lane: shifts bits in, first received ends lowest
`timescale 1ns/1ns
`default_nettype none
module lane_shifter #(
  parameter int WIDTH = 7
) (
  input  wire logic             clk_in,
  input  wire logic             clear_in,
  input  wire logic             bit_en_in,
  input  wire logic             bit_in,
  output logic      [WIDTH-1:0] word_out
);
  typedef struct packed {
    logic [WIDTH-1:0] shreg;
  } shifter_state_t;

  shifter_state_t state_q;
  shifter_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (clear_in)
      state_d.shreg = '0;
    else if (bit_en_in)
      state_d.shreg = {bit_in, state_q.shreg[WIDTH-1:1]};
  end

  always_ff @(posedge clk_in)
  begin
    state_q <= state_d;
  end

  assign word_out = state_q.shreg;
endmodule // lane_shifter
`default_nettype wire

// >>> verilog/lane_deserializer.sv
// three lane seven to one deserializer with word clock regeneration
//
// Overview of operation
// - three independent lane shifters each build a 7-bit word.
// - lanes are sampled at seven bit slots per link clock period.
// - once per link period the three words load one 21-bit output.
// - output data changes on the word clock rise, valid at its fall.
// - shutdown stops clocking and powers down the lane receivers.
// - shutdown low clears the word, word clock, lock state, lock, edge and slot counters and lane shifters to zero.
// - lock is acquired over the supported link clock frequency range.
// - the word is passed with no encoding added or removed.
// - lock is reached within about 1 ms of shutdown release.
// - the off state is entered within about 400 ns of shutdown.
`timescale 1ns/1ns
`default_nettype none
`include "deser_defs.svh"
module lane_deserializer #(
  parameter int LOCK_CYCLES = `LOCK_CYCLES,
  parameter int BIT_DIV     = `LANE_BITS
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         shutdown_clear_n,
  input  wire logic                         link_clock_pos,
  input  wire logic                         link_clock_neg,
  input  wire deser_pkg::lane_pins_t        lane_pins_in,
  output logic      [`WORD_BITS-1:0]        parallel_word_bits,
  output logic                              parallel_word_clock,
  output logic                              lane_rx_enable_out,
  output logic                              locked_out
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0]              shdn_sync;
    logic [1:0]              clk_sync;
    logic [`LANE_COUNT-1:0]  lane_sync0;
    logic [`LANE_COUNT-1:0]  lane_sync1;
    logic                    clk_prev;
    deser_pkg::lock_state_t  lock_st;
    logic [31:0]             lock_cnt;
    logic [3:0]              edge_cnt;
    logic [3:0]              off_cnt;
    logic [2:0]              slot;
    logic [`WORD_BITS-1:0]   word;
    logic                    word_clk;
    logic                    rx_en;
  } deser_state_t;

  deser_state_t state_q;
  deser_state_t state_d;

  logic                  off_now;
  logic                  link_rise;
  logic                  bit_en;
  logic                  clear;
  logic [`LANE_COUNT-1:0] lane_bit;
  logic [`LANE_BITS-1:0] lane_word [`LANE_COUNT];

  // shutdown is active low; rst_in acts as a forced shutdown
  assign off_now   = rst_in || !state_q.shdn_sync[1];
  assign clear     = off_now;
  // the differential pair is resolved before synchronising
  assign link_rise = state_q.clk_sync[1] && !state_q.clk_prev;
  // one bit slot per clk edge: the 25 MHz core cannot truly oversample
  // a 31-68 MHz link, so slots are paced by a divider enable;
  // the first bit of a period stands at the detected rise, so it shifts
  // there, and the eighth slot carries no bit and is skipped
  assign bit_en    = (state_q.lock_st == deser_pkg::ST_LOCKED)
                     && (link_rise
                         || (state_q.slot < 3'(BIT_DIV - 1)));
  assign lane_bit  = state_q.lane_sync1;

  // ==========================================================
  // lane shifters
  genvar g;
  generate
    for (g = 0; g < `LANE_COUNT; g++)
    begin : g_lane
      lane_shifter #(
        .WIDTH     (`LANE_BITS)
      ) u_lane (
        .clk_in    (clk_in),
        .clear_in  (clear),
        .bit_en_in (bit_en),
        .bit_in    (lane_bit[g]),
        .word_out  (lane_word[g])
      );
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb
  begin
    state_d            = state_q;
    state_d.shdn_sync  = {state_q.shdn_sync[0], shutdown_clear_n};
    state_d.clk_sync   = {state_q.clk_sync[0],
                          link_clock_pos && !link_clock_neg};
    state_d.lane_sync0 = lane_pins_in.pos & ~lane_pins_in.neg;
    state_d.lane_sync1 = state_q.lane_sync0;
    state_d.clk_prev   = state_q.clk_sync[1];
    if (off_now)
    begin
      // lock state, lock, edge and slot counts, word and lane samples to zero, word clock parked low
      state_d.lock_st  = deser_pkg::ST_OFF;
      state_d.lock_cnt = '0;
      state_d.edge_cnt = '0;
      state_d.slot     = '0;
      state_d.word     = '0;
      state_d.word_clk = 1'b0;
      state_d.lane_sync0 = '0;
      state_d.lane_sync1 = '0;
      if (state_q.off_cnt < 4'(`OFF_CYCLES))
        state_d.off_cnt = state_q.off_cnt + 4'h1;
      else
        state_d.rx_en = 1'b0;
      if (rst_in)
      begin
        state_d.rx_en   = 1'b0;
        state_d.off_cnt = '0;
      end
    end
    else
    begin
      state_d.off_cnt = '0;
      state_d.rx_en   = 1'b1;
      case (state_q.lock_st)
        deser_pkg::ST_OFF:
          state_d.lock_st = deser_pkg::ST_ACQUIRE;
        deser_pkg::ST_ACQUIRE:
        begin
          // wait for steady link edges and the lock time
          if (state_q.lock_cnt < 32'(LOCK_CYCLES))
            state_d.lock_cnt = state_q.lock_cnt + 32'h1;
          if (link_rise && state_q.edge_cnt != 4'(`LOCK_EDGES))
            state_d.edge_cnt = state_q.edge_cnt + 4'h1;
          if (state_q.lock_cnt >= 32'(LOCK_CYCLES)
              && state_q.edge_cnt == 4'(`LOCK_EDGES))
            state_d.lock_st = deser_pkg::ST_LOCKED;
        end
        deser_pkg::ST_LOCKED:
        begin
          if (link_rise)
          begin
            state_d.slot = '0;
            // transparent load, lane n at bits 7n..7n+6
            state_d.word = {lane_word[2], lane_word[1],
                            lane_word[0]};
            state_d.word_clk = 1'b1;
          end
          else
          begin
            if (state_q.slot != 3'(BIT_DIV))
              state_d.slot = state_q.slot + 3'h1;
            if (state_q.slot >= 3'(BIT_DIV / 2))
              state_d.word_clk = 1'b0;
          end
        end
        default:
          state_d.lock_st = deser_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    state_q <= state_d;
  end

  assign parallel_word_bits  = state_q.word;
  assign parallel_word_clock = state_q.word_clk;
  assign lane_rx_enable_out  = state_q.rx_en;
  assign locked_out = (state_q.lock_st == deser_pkg::ST_LOCKED);
endmodule // lane_deserializer
`default_nettype wire

// >>> verification/tx_model.sv
// transmitter model: link clock and three serial lanes
`timescale 1ns/1ns
`default_nettype none
module tx_model (
  input  wire logic [20:0]      word_in,
  output logic                  clk_p_out,
  output logic                  clk_n_out,
  output deser_pkg::lane_pins_t pins_out
);
  assign clk_n_out = ~clk_p_out;
  initial
  begin
    clk_p_out = 1'b0;
    pins_out = '0;
    // change one step after a core clock edge, like the bench stimulus
    #21;
    forever
      for (int k = 0; k < 8; k++)
      begin
        clk_p_out = (k < 4);
        // slot 7 has no bit: show the inverse, never a stale value
        for (int l = 0; l < 3; l++)
          pins_out.pos[l] = (k < 7) ? word_in[7*l+k] : ~pins_out.pos[l];
        pins_out.neg = ~pins_out.pos;
        #40;
      end
  end
endmodule // tx_model
`default_nettype wire

// >>> verification/deser_assertions.sv
// port checks for the deserializer
`timescale 1ns/1ns
`default_nettype none
module deser_assertions #(parameter int LOCK_CYCLES = 20) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        shutdown_clear_n,
  input wire logic [20:0] parallel_word_bits,
  input wire logic        parallel_word_clock,
  input wire logic        lane_rx_enable_out,
  input wire logic        locked_out
);
  int unsigned on_q;
  always_ff @(posedge clk_in)
    on_q <= (rst_in || !lane_rx_enable_out) ? 0 : on_q + 1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  shut_clear_a: assert property (!shutdown_clear_n [*5] |->
    parallel_word_bits == 0 && !parallel_word_clock && !locked_out)
    else $error("not cleared");
  rx_off_a: assert property ($fell(shutdown_clear_n) |->
    ##[1:14] !lane_rx_enable_out) else $error("receivers on");
  lock_rx_a: assert property (locked_out |-> lane_rx_enable_out)
    else $error("locked while off");
  lock_wait_a: assert property ($rose(locked_out) |->
    on_q >= LOCK_CYCLES) else $error("early lock");
  lock_bound_a: assert property (on_q < LOCK_CYCLES + 1000 || locked_out)
    else $error("no lock");
  idle_clock_a: assert property (parallel_word_clock |-> locked_out)
    else $error("clock before lock");
  word_hold_a: assert property (parallel_word_clock &&
    $past(parallel_word_clock) |-> $stable(parallel_word_bits))
    else $error("word moved");
  clock_fall_a: assert property ($rose(parallel_word_clock) |->
    ##[1:7] !parallel_word_clock) else $error("clock stuck");
  word_rate_a: assert property ($rose(parallel_word_clock) |=>
    (!$rose(parallel_word_clock)) [*6]) else $error("words too close");
  cover property ($fell(parallel_word_clock));
  cover property ($rose(locked_out));
  cover property ($fell(lane_rx_enable_out));
endmodule // deser_assertions
bind lane_deserializer deser_assertions #(.LOCK_CYCLES(LOCK_CYCLES)) chk_i (.*);
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the three lane deserializer
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                  clk_in = 1'b0;
  logic                  rst_in = 1'b1;
  logic                  sd_n = 1'b1;
  logic [20:0]           tx_word = 21'h000000;
  logic [20:0]           word;
  logic                  lk_p, lk_n, wclk, rx_en, lock;
  deser_pkg::lane_pins_t pins;
  int                    err_total = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  always #20 clk_in = ~clk_in;
  tx_model tx_model_i (.word_in(tx_word), .clk_p_out(lk_p),
    .clk_n_out(lk_n), .pins_out(pins));
  lane_deserializer #(.LOCK_CYCLES(20)) lane_deserializer_i (
    .clk_in(clk_in), .rst_in(rst_in), .shutdown_clear_n(sd_n),
    .link_clock_pos(lk_p), .link_clock_neg(lk_n), .lane_pins_in(pins),
    .parallel_word_bits(word), .parallel_word_clock(wclk),
    .lane_rx_enable_out(rx_en), .locked_out(lock));
  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic t_lock;
    for (int i = 0; i < 400 && lock !== 1'b1; i++)
      tick(1);
    check(21'({rx_en, lock}), 21'h000003);
    $display("lock test done");
  endtask
  task automatic t_words;
    logic [20:0] tab [3] = '{21'h000001, 21'h0c1a55, 21'h1f00fe};
    for (int w = 0; w < 3; w++)
    begin
      tx_word = tab[w];
      tick(40);
      for (int i = 0; i < 20 && wclk !== 1'b1; i++)
        tick(1);
      // data is taken where the word clock falls
      for (int i = 0; i < 20 && wclk === 1'b1; i++)
        tick(1);
      check(word, tab[w]);
    end
    $display("word test done");
  endtask
  task automatic t_shut;
    sd_n = 1'b0;
    tick(15);
    check(word, 21'h000000);
    check(21'({wclk, rx_en, lock}), 21'h000000);
    sd_n = 1'b1;
    $display("shutdown test done");
  endtask
  initial
  begin
    tick(20);
    check(word | 21'({wclk, rx_en, lock}), 21'h000000);
    rst_in = 1'b0;
    t_lock;
    t_words;
    t_shut;
    t_lock;
    t_words;
    complete_run;
  end
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      complete_run;
    end
  end
endmodule // tb
`default_nettype wire
